// ### hw/pm_cap_pkg.sv
// Purpose: shared constants and carriers for the power capability word
// Assumes: 16-bit configuration accesses addressed by byte offset
// Notes: fixed fields of the word are held here once
package pm_cap_pkg;

  // ------------------------------------------------------------------
  // configuration space offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] power_capability_word_offset = 8'h46;
  localparam logic [7:0] misc_config_offset = 8'hf0;

  // ------------------------------------------------------------------
  // field positions of the capability word
  // ------------------------------------------------------------------
  localparam int cold_wake_capable_bit = 15;
  localparam int wake_state_mask_lsb = 11;
  localparam int second_sleep_state_bit = 10;
  localparam int first_sleep_state_bit = 9;
  localparam int aux_current_lsb = 6;
  localparam int dev_init_bit = 5;
  localparam int reserved_bit = 4;
  localparam int wake_needs_clock_bit = 3;
  localparam int power_spec_revision_lsb = 0;
  // position of the mirrored bit inside the miscellaneous register
  localparam int misc_cold_wake_bit = 15;

  // ------------------------------------------------------------------
  // field values
  // ------------------------------------------------------------------
  localparam logic [3:0] wake_state_mask_value = 4'hf;
  localparam logic second_sleep_state_value = 1'b1;
  localparam logic first_sleep_state_value = 1'b1;
  localparam logic [2:0] aux_current_self = 3'h0;
  localparam logic [2:0] aux_current_55ma = 3'h1;
  localparam logic dev_init_value = 1'b0;
  localparam logic reserved_value = 1'b0;
  localparam logic wake_needs_clock_value = 1'b0;
  localparam logic [2:0] power_spec_revision_value = 3'h2;

  // ------------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------------
  localparam logic [15:0] power_capability_reset = 16'h7e02;
  localparam logic cold_wake_reset = 1'b0;
  localparam logic [15:0] read_data_reset = 16'h0000;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [1:0] byte_en;
    logic [15:0] wdata;
  } cfg_req_type;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } cfg_rsp_type;

endpackage

// ### hw/cold_wake_store.sv
// Purpose: holds the cold-wake bit of the miscellaneous configuration register
// Assumes: rom load and configuration write arrive synchronous to sys_clk_in
// Notes: a rom load in the same cycle as a write takes precedence
`timescale 1ns/1ps
`default_nettype none

module cold_wake_store
  import pm_cap_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic rom_load_in,
  input wire logic rom_bit_in,
  input wire logic cfg_write_in,
  input wire logic cfg_bit_in,
  output logic cold_wake_out,
  output logic rom_loaded_out
);

  logic cold_wake;
  logic next_cold_wake;
  logic rom_loaded;
  logic next_rom_loaded;

  // ------------------------------------------------------------------
  // next value of the stored bit
  // ------------------------------------------------------------------
  always_comb
  begin
    next_cold_wake = cold_wake;
    next_rom_loaded = rom_loaded;
    if (rom_load_in)
    begin
      next_cold_wake = rom_bit_in; // [R3]
      next_rom_loaded = 1'b1;
    end
    else if (cfg_write_in)
    begin
      next_cold_wake = cfg_bit_in; // [R2]
    end
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cold_wake <= cold_wake_reset;
      rom_loaded <= 1'b0;
    end
    else if (clk_en_in)
    begin
      cold_wake <= next_cold_wake;
      rom_loaded <= next_rom_loaded;
    end
  end

  assign cold_wake_out = cold_wake;
  assign rom_loaded_out = rom_loaded;

endmodule // cold_wake_store

`default_nettype wire

// ### hw/power_capability_word.sv
// Purpose: power capability word of the configuration space, with its source
// Assumes: one configuration access at a time, answered one cycle later
// Notes: the word is read-only; only the mirrored cold-wake bit and aux current bit 6 can change
//
// Contract
// R1: the 16-bit capability word sits at offset 46h and reads 7E02h after reset.
// R2: bit 15 follows bit 15 of the miscellaneous register at F0h.
// R3: that miscellaneous bit is loaded from the serial configuration rom.
// R4: bit 15 set advertises wake events from cold D3, clear advertises none.
// R5: bits 14 to 11 read 1111b, wake allowed from D3hot, D2, D1 and D0.
// R6: bit 10 reads 1, the second sleep state is supported.
// R7: bit 9 reads 1, the first sleep state is supported.
// R8: bits 8 to 6 read 000b with bit 15 clear and 001b (55 mA) with it set.
// R9: bit 5 reads 0, no device-specific initialisation is needed.
// R10: bit 4 is reserved and reads 0.
// R11: bit 3 reads 0, no bus clock is needed to raise a wake event.
// R12: bits 2 to 0 read 010b, the supported power-management revision.
// R13: writes to the capability word change nothing in it.
`timescale 1ns/1ps
`default_nettype none

module power_capability_word
  import pm_cap_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire cfg_req_type cfg_req_in,
  output cfg_rsp_type cfg_rsp_out,
  output logic cfg_ready_out,
  input wire logic rom_load_in,
  input wire logic [15:0] rom_misc_word_in,
  output logic [15:0] power_capability_out,
  output logic cold_wake_capable_out,
  output logic rom_loaded_out,
  output logic write_ignored_out
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // true when an access hits the given word offset
  function automatic logic hits(input logic [7:0] addr,
                                input logic [7:0] offset);
    hits = (addr == offset);
  endfunction

  // builds the capability word from the cold-wake bit
  function automatic logic [15:0] compose(input logic cold);
    logic [15:0] word;
    word = 16'h0000;
    word[cold_wake_capable_bit] = cold; // [R2] [R4]
    word[wake_state_mask_lsb +: 4] = wake_state_mask_value; // [R5]
    word[second_sleep_state_bit] = second_sleep_state_value; // [R6]
    word[first_sleep_state_bit] = first_sleep_state_value; // [R7]
    word[aux_current_lsb +: 3] = cold ? aux_current_55ma
                                      : aux_current_self; // [R8]
    word[dev_init_bit] = dev_init_value; // [R9]
    word[reserved_bit] = reserved_value; // [R10]
    word[wake_needs_clock_bit] = wake_needs_clock_value; // [R11]
    word[power_spec_revision_lsb +: 3] = power_spec_revision_value; // [R12]
    compose = word;
  endfunction

  // ------------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_reply = 2'b10
  } access_state_type;

  access_state_type state;
  access_state_type next_state;
  logic [15:0] read_data;
  logic [15:0] next_read_data;
  logic ignored;
  logic next_ignored;
  logic [15:0] cap_word;
  logic [15:0] next_cap_word;
  logic misc_write;
  logic cold_wake;
  logic take;

  // a request is taken only while idle and enabled
  assign take = clk_en_in && cfg_req_in.valid && (state == st_idle);

  // write to the high byte of the miscellaneous register low half
  assign misc_write = take && cfg_req_in.write && cfg_req_in.byte_en[1]
                      && hits(cfg_req_in.addr, misc_config_offset); // [R2]

  // ------------------------------------------------------------------
  // mirrored miscellaneous bit
  // ------------------------------------------------------------------
  cold_wake_store u_store (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .rom_load_in(rom_load_in), // [R3]
    .rom_bit_in(rom_misc_word_in[misc_cold_wake_bit]),
    .cfg_write_in(misc_write),
    .cfg_bit_in(cfg_req_in.wdata[misc_cold_wake_bit]),
    .cold_wake_out(cold_wake),
    .rom_loaded_out(rom_loaded_out)
  );

  // ------------------------------------------------------------------
  // next state of the access sequencer and its answer
  // ------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_read_data = read_data;
    next_ignored = 1'b0;
    case (state)
      st_idle:
      begin
        if (take)
        begin
          next_state = st_reply;
          next_read_data = 16'h0000;
          if (!cfg_req_in.write)
          begin
            if (hits(cfg_req_in.addr, power_capability_word_offset))
            begin
              next_read_data = cap_word; // [R1]
            end
            else if (hits(cfg_req_in.addr, misc_config_offset))
            begin
              next_read_data[misc_cold_wake_bit] = cold_wake;
            end
          end
          else if (hits(cfg_req_in.addr, power_capability_word_offset))
          begin
            next_ignored = 1'b1; // [R13]
          end
        end
      end
      st_reply:
      begin
        next_state = st_idle;
      end
      default:
      begin
        next_state = st_idle;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // capability word: rebuilt from the mirrored bit only
  // ------------------------------------------------------------------
  always_comb
  begin
    next_cap_word = compose(cold_wake); // [R13]
  end

  // registers of the sequencer and of the word
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= st_idle;
      read_data <= read_data_reset;
      ignored <= 1'b0;
      cap_word <= power_capability_reset; // [R1]
    end
    else if (clk_en_in)
    begin
      state <= next_state;
      read_data <= next_read_data;
      ignored <= next_ignored;
      cap_word <= next_cap_word;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign cfg_ready_out = (state == st_idle);
  assign cfg_rsp_out = '{ack: (state == st_reply), rdata: read_data};
  assign power_capability_out = cap_word;
  assign cold_wake_capable_out = cap_word[cold_wake_capable_bit]; // [R4]
  assign write_ignored_out = ignored;

endmodule // power_capability_word

`default_nettype wire

// ### tb/pm_cap_assertions.sv
// Purpose: port checks for the power capability word
// Assumes: clk_en_in high around accesses
// Notes: bound to power_capability_word
`timescale 1ns/1ps
`default_nettype none
module pm_cap_assertions
  import pm_cap_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire cfg_req_type cfg_req_in,
  input wire cfg_rsp_type cfg_rsp_out,
  input wire logic cfg_ready_out,
  input wire logic rom_load_in,
  input wire logic [15:0] rom_misc_word_in,
  input wire logic [15:0] power_capability_out,
  input wire logic cold_wake_capable_out,
  input wire logic rom_loaded_out,
  input wire logic write_ignored_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // -----------------------
  // access steps
  // -----------------------
  sequence taken_s;
    cfg_req_in.valid && cfg_ready_out && clk_en_in;
  endsequence
  sequence reply_s;
    (cfg_rsp_out.ack && !cfg_ready_out)
    ##1 (!cfg_rsp_out.ack && cfg_ready_out);
  endsequence
  chk_upper_fields : assert property (
    power_capability_out[14:6] == (power_capability_out[15] ? 9'h1f9 : 9'h1f8))
    else $error("upper fields wrong");
  chk_lower_fields : assert property (
    power_capability_out[5:0] == 6'h02) else $error("lower fields wrong");
  chk_rom_load_bit : assert property (
    (rom_load_in && clk_en_in) ##1 clk_en_in |=> rom_loaded_out &&
    cold_wake_capable_out == $past(rom_misc_word_in[15], 2))
    else $error("rom load");
  chk_word_mirror : assert property (
    taken_s ##0 (cfg_req_in.write && cfg_req_in.byte_en[1] && !rom_load_in
    && cfg_req_in.addr == misc_config_offset) ##1 clk_en_in |=>
    power_capability_out[15] == $past(cfg_req_in.wdata[15], 2) &&
    cold_wake_capable_out == power_capability_out[15])
    else $error("bit 15 not mirrored");
  chk_read_reply : assert property (
    taken_s ##0 (!cfg_req_in.write && cfg_req_in.addr == 8'h46) |=>
    cfg_rsp_out.rdata == $past(power_capability_out)) else $error("read data");
  chk_reply_timing : assert property (
    taken_s ##1 clk_en_in |-> reply_s) else $error("reply timing");
  chk_write_flag : assert property (
    taken_s ##0 (cfg_req_in.write && cfg_req_in.addr == 8'h46) |=>
    write_ignored_out && cfg_rsp_out.ack) else $error("write flag");
  chk_write_no_effect : assert property (
    write_ignored_out && !$past(rom_load_in) |=> $stable(cold_wake_capable_out))
    else $error("ignored write changed bit");
endmodule // pm_cap_assertions
bind power_capability_word pm_cap_assertions chk (.sys_clk_in, .rst_n_in,
  .clk_en_in, .cfg_req_in, .cfg_rsp_out, .cfg_ready_out, .rom_load_in,
  .rom_misc_word_in, .power_capability_out, .cold_wake_capable_out,
  .rom_loaded_out, .write_ignored_out);
`default_nettype wire

// ### tb/tb_power_capability_word.sv
// Purpose: self-checking bench for the power capability word
// Assumes: one access per two cycles
// Notes: the model keeps the cold-wake bit and predicts each read
`timescale 1ns/1ps
`default_nettype none
module tb_power_capability_word
  import pm_cap_pkg::*;
();
  logic sys_clk_in, rst_n_in, clk_en_in, rom_load_in, cfg_ready_out;
  logic cold_wake_capable_out, rom_loaded_out, write_ignored_out, wi;
  logic [15:0] rom_misc_word_in, power_capability_out, rd;
  logic [31:0] r;
  cfg_req_type cfg_req_in;
  cfg_rsp_type cfg_rsp_out;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 44;
  int cold = 0;
  power_capability_word DUT (.sys_clk_in, .rst_n_in, .clk_en_in, .cfg_req_in,
    .cfg_rsp_out, .cfg_ready_out, .rom_load_in, .rom_misc_word_in,
    .power_capability_out, .cold_wake_capable_out, .rom_loaded_out,
    .write_ignored_out);
  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // predicted word for a given cold-wake bit
  function automatic logic [15:0] exp_word(input int c);
    exp_word = {c[0], wake_state_mask_value, second_sleep_state_value,
      first_sleep_state_value, c[0] ? aux_current_55ma : aux_current_self,
      dev_init_value, reserved_value, wake_needs_clock_value,
      power_spec_revision_value};
  endfunction
  // one configuration access, request held over the take edge
  task automatic access(input logic w, input logic [7:0] a,
    input logic [1:0] be, input logic [15:0] d);
    logic [15:0] exp;
    int n;
    n = 0;
    exp = (!w && a == 8'h46) ? exp_word(cold) : 16'h0000;
    if (!w && a == 8'hf0) exp = {cold[0], 15'h0};
    @(negedge sys_clk_in);
    while (cfg_ready_out !== 1'b1 && n < 8)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    check(power_capability_out, exp_word(cold));
    check({15'h0, cold_wake_capable_out}, 16'(cold));
    cfg_req_in = '{1'b1, w, a, be, d};
    @(negedge sys_clk_in);
    cfg_req_in.valid = 1'b0;
    rd = cfg_rsp_out.rdata;
    wi = write_ignored_out;
    check({15'h0, cfg_rsp_out.ack}, 16'h0001);
    if (!w) check(rd, exp);
    if (w) check({15'h0, wi}, {15'h0, a == 8'h46});
    if (w && a == 8'hf0 && be[1]) cold = d[15];
  endtask
  // rom image load pulse, image scrambled afterwards
  task automatic rom_load(input logic [15:0] d);
    @(negedge sys_clk_in);
    rom_load_in = 1'b1;
    rom_misc_word_in = d;
    @(negedge sys_clk_in);
    rom_load_in = 1'b0;
    rom_misc_word_in = ~d;
    cold = d[15];
    check({15'h0, rom_loaded_out}, 16'h0001);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // hang guard
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  // -----------------------
  // main sequence
  // -----------------------
  initial
  begin
    rst_n_in = 1'b0;
    clk_en_in = 1'b1;
    rom_load_in = 1'b0;
    rom_misc_word_in = 16'h0000;
    cfg_req_in = '0;
    repeat (5) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    access(1'b0, 8'h46, 2'h3, 16'h0000);
    rom_load(16'h8000 | 16'($random(seed)));
    access(1'b0, 8'h46, 2'h3, 16'h0000);
    access(1'b1, 8'h46, 2'h3, 16'h0000);
    access(1'b1, 8'hf0, 2'h1, 16'h0000);
    access(1'b1, 8'hf0, 2'h2, 16'h0000);
    access(1'b1, 8'h46, 2'h3, 16'hffff);
    access(1'b0, 8'h47, 2'h3, 16'h0000);
    // freeze in the reply cycle: ack holds and a rom pulse is ignored
    clk_en_in = 1'b0;
    rom_load_in = 1'b1;
    rom_misc_word_in = {~cold[0], 15'h0};
    repeat (3) @(negedge sys_clk_in);
    check({15'h0, cfg_rsp_out.ack}, 16'h0001);
    check(power_capability_out, exp_word(cold));
    rom_load_in = 1'b0;
    clk_en_in = 1'b1;
    for (int i = 0; i < 60; i++)
    begin
      r = $random(seed);
      if (r[1:0] == 2'h0)
        rom_load(r[31:16]);
      else
        access(r[2], r[1:0] == 2'h1 ? 8'h46 : r[1:0] == 2'h2 ? 8'hf0 : r[15:8],
          r[4:3], r[31:16]);
    end
    rom_load(16'h8000);
    access(1'b0, 8'h46, 2'h3, 16'h0000);
    // mid-run reset with the cold-wake bit set, then a read after release
    rst_n_in = 1'b0;
    cold = 0;
    @(negedge sys_clk_in);
    check(power_capability_out, 16'h7e02);
    check({15'h0, rom_loaded_out}, 16'h0000);
    rst_n_in = 1'b1;
    access(1'b0, 8'h46, 2'h3, 16'h0000);
    end_of_test();
  end
endmodule // tb_power_capability_word
`default_nettype wire
